// ### inc/scan_tap_pkg.sv
// Constants and types for the boundary-scan test access port
package scan_tap_pkg;
    localparam int unsigned IR_WIDTH  = 3;
    localparam int unsigned BSR_WIDTH = 69;
    localparam int unsigned ID_WIDTH  = 32;
    localparam int unsigned TMS_SYNC_DEPTH = 2;

    typedef logic [IR_WIDTH-1:0]  instr_t;
    typedef logic [BSR_WIDTH-1:0] ring_t;
    typedef logic [ID_WIDTH-1:0]  ident_t;

    // Instruction encodings, free parameters of the design
    localparam instr_t INSTR_EXT_TEST   = 3'h0;
    localparam instr_t INSTR_IDENT      = 3'h1;
    localparam instr_t INSTR_SAMPLE_Z   = 3'h2;
    localparam instr_t INSTR_SAMPLE     = 3'h4;
    localparam instr_t INSTR_BYPASS     = 3'h7;

    localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
    // Arbitrary neutral identification value
    localparam ident_t IDENT_VALUE = 32'h0000_0001;

    // Controller states, Gray-coded along the usual path
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h3,
        ST_CAP_DR     = 4'h2,
        ST_SHIFT_DR   = 4'h6,
        ST_EXIT1_DR   = 4'h7,
        ST_PAUSE_DR   = 4'h5,
        ST_EXIT2_DR   = 4'h4,
        ST_UPD_DR     = 4'hC,
        ST_SEL_IR     = 4'hD,
        ST_CAP_IR     = 4'hF,
        ST_SHIFT_IR   = 4'hE,
        ST_EXIT1_IR   = 4'hA,
        ST_PAUSE_IR   = 4'hB,
        ST_EXIT2_IR   = 4'h9,
        ST_UPD_IR     = 4'h8
    } tap_state_t;

    typedef enum logic [1:0] {
        PATH_BYPASS = 2'h0,
        PATH_IDENT  = 2'h1,
        PATH_RING   = 2'h2
    } path_t;
endpackage : scan_tap_pkg

// ### logic/sram_boundary_scan_tap.sv
// Boundary-scan test access port with a reduced instruction set
// Functional notes
// RL1: Standard controller state machine and registers; reduced instruction set only.
// RL2: All scan inputs sampled on test clock rising edge.
// RL3: Serial output changes only on test clock falling edge.
// RL4: Undriven mode select reads high, so idle port stays in reset.
// RL5: Serial output enabled only in shifting states, else floating.
// RL6: Registers shift toward LSB; input at MSB, LSB drives output.
// RL7: Loaded instruction selects exactly one register into the path.
// RL8: Five rising edges with mode select high force reset state.
// RL9: Scan reset leaves memory operation untouched.
// RL10: Power-up reset puts serial output in floating state.
// RL11: Instruction register three bits, loaded serially during instruction shift.
// RL12: Identification instruction loaded after power-up and every reset state.
// RL13: Capture-instruction loads binary 01 into two lowest shift bits.
// RL14: Bypass is one bit, cleared when bypass instruction executes.
// RL15: Pin ring register is 69 bits in fixed pin order.
// RL16: Capture-data loads pin ring; shift-data shifts it out.
// RL17: External-test, sample and sample-floating all capture the pin ring.
// RL18: Identification instruction captures hardwired 32-bit value, then shifts it.
// RL19: Unused systems hold test clock low permanently.
// RL20: All-zero instruction acts as sample, without floating outputs.
// RL21: Sample-floating forces memory outputs floating and selects pin ring.
// RL22: Update-data under sample changes nothing.
// RL23: Controller never loads reserved instruction encodings; the code loads any shifted encoding at update-instruction.
// RL24: Instruction encodings are design parameters.
// RL25: Undecoded encodings select the bypass register.
`timescale 1ns/1ps
module sram_boundary_scan_tap
    import scan_tap_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 tck_in,
    input  wire logic                 tms_in,
    input  wire logic                 tms_driven_in,
    input  wire logic                 tdi_in,
    input  wire scan_tap_pkg::ring_t  pin_ring_in,
    output logic                      tdo_out,
    output logic                      tdo_oe_n_out,
    output logic                      mem_outputs_float_out,
    output scan_tap_pkg::instr_t      scan_instruction_out,
    output logic                      tap_reset_out
);
    import scan_tap_pkg::*;

    logic [TMS_SYNC_DEPTH-1:0] tck_sync_reg;
    logic [TMS_SYNC_DEPTH-1:0] tms_sync_reg;
    logic [TMS_SYNC_DEPTH-1:0] tmsd_sync_reg;
    logic [TMS_SYNC_DEPTH-1:0] tdi_sync_reg;
    logic                      tck_prev_reg;
    logic                      tck_rise;
    logic                      tck_fall;
    logic                      tms_eff;
    logic                      tdi_s;

    tap_state_t                state_reg;
    tap_state_t                state_next;
    instr_t                    scan_instruction_reg;
    instr_t                    ir_shift_reg;
    logic                      scan_bypass_bit_reg;
    ring_t                     ring_meta_reg;
    ring_t                     ring_sync_reg;
    ring_t                     pin_ring_capture_reg;
    ident_t                    device_identification_reg;
    path_t                     path;
    logic                      serial_bit;
    logic                      shifting;
    logic                      tdo_reg;
    logic                      tdo_oe_n_reg;

    // Decode the register placed in the data path
    function automatic path_t decode_path(input instr_t ins);
        case (ins) // RL24
            INSTR_EXT_TEST: decode_path = PATH_RING; // RL17 RL20
            INSTR_SAMPLE:   decode_path = PATH_RING; // RL17
            INSTR_SAMPLE_Z: decode_path = PATH_RING; // RL21
            INSTR_IDENT:    decode_path = PATH_IDENT;
            default:        decode_path = PATH_BYPASS; // RL25 RL23
        endcase
    endfunction : decode_path

    // Two-stage synchronisers for the scan pins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tck_sync_reg  <= '0;
            tms_sync_reg  <= '1;
            tmsd_sync_reg <= '0;
            tdi_sync_reg  <= '1;
            tck_prev_reg  <= 1'b0;
        end else if (clk_en_in) begin
            tck_sync_reg  <= {tck_sync_reg[0], tck_in};
            tms_sync_reg  <= {tms_sync_reg[0], tms_in};
            tmsd_sync_reg <= {tmsd_sync_reg[0], tms_driven_in};
            tdi_sync_reg  <= {tdi_sync_reg[0], tdi_in};
            tck_prev_reg  <= tck_sync_reg[1];
        end
    end

    // Two-stage synchroniser for the pin ring
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ring_meta_reg <= '0;
            ring_sync_reg <= '0;
        end else if (clk_en_in) begin
            ring_meta_reg <= pin_ring_in;
            ring_sync_reg <= ring_meta_reg;
        end
    end

    assign tck_rise = clk_en_in & tck_sync_reg[1] & ~tck_prev_reg; // RL2
    assign tck_fall = clk_en_in & ~tck_sync_reg[1] & tck_prev_reg; // RL3
    assign tms_eff  = tms_sync_reg[1] | ~tmsd_sync_reg[1]; // RL4
    assign tdi_s    = tdi_sync_reg[1];
    assign path     = decode_path(scan_instruction_reg); // RL7

    // Controller next state
    always_comb begin
        case (state_reg) // RL1 RL8
            ST_RESET:    state_next = tms_eff ? ST_RESET   : ST_IDLE;
            ST_IDLE:     state_next = tms_eff ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:   state_next = tms_eff ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   state_next = tms_eff ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = tms_eff ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = tms_eff ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = tms_eff ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = tms_eff ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   state_next = tms_eff ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:   state_next = tms_eff ? ST_RESET   : ST_CAP_IR;
            ST_CAP_IR:   state_next = tms_eff ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = tms_eff ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = tms_eff ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = tms_eff ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = tms_eff ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   state_next = tms_eff ? ST_SEL_DR  : ST_IDLE;
            default:     state_next = ST_RESET;
        endcase
    end

    // Controller state, reset at power-up
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_RESET; // RL10
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // Instruction shift stage and active instruction
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ir_shift_reg         <= INSTR_IDENT;
            scan_instruction_reg <= INSTR_IDENT; // RL12
        end else if (tck_rise) begin
            case (state_reg)
                ST_RESET: begin
                    scan_instruction_reg <= INSTR_IDENT; // RL12
                end
                ST_CAP_IR: begin
                    ir_shift_reg <= {ir_shift_reg[IR_WIDTH-1:2], IR_CAPTURE_PATTERN}; // RL13
                end
                ST_SHIFT_IR: begin
                    ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]}; // RL11 RL6
                end
                ST_UPD_IR: begin
                    scan_instruction_reg <= ir_shift_reg; // RL11
                end
                default: begin
                end
            endcase
            if (state_next == ST_RESET) begin
                scan_instruction_reg <= INSTR_IDENT; // RL12
            end
        end
    end

    // Bypass bit
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scan_bypass_bit_reg <= 1'b0;
        end else if (tck_rise && path == PATH_BYPASS) begin
            if (state_reg == ST_CAP_DR) begin
                scan_bypass_bit_reg <= 1'b0; // RL14
            end else if (state_reg == ST_SHIFT_DR) begin
                scan_bypass_bit_reg <= tdi_s;
            end
        end
    end

    // Pin ring capture, no update stage so update acts as a pause
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_ring_capture_reg <= '0;
        end else if (tck_rise && path == PATH_RING) begin
            if (state_reg == ST_CAP_DR) begin
                pin_ring_capture_reg <= ring_sync_reg; // RL16 RL15
            end else if (state_reg == ST_SHIFT_DR) begin
                pin_ring_capture_reg <= {tdi_s, pin_ring_capture_reg[BSR_WIDTH-1:1]}; // RL6 RL16
            end
        end
    end // RL22

    // Identification register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            device_identification_reg <= '0;
        end else if (tck_rise && path == PATH_IDENT) begin
            if (state_reg == ST_CAP_DR) begin
                device_identification_reg <= IDENT_VALUE; // RL18
            end else if (state_reg == ST_SHIFT_DR) begin
                device_identification_reg <= {tdi_s, device_identification_reg[ID_WIDTH-1:1]}; // RL18 RL6
            end
        end
    end

    // Serial output source
    always_comb begin
        shifting = (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);
        if (state_reg == ST_SHIFT_IR) begin
            serial_bit = ir_shift_reg[0];
        end else begin
            case (path)
                PATH_RING:  serial_bit = pin_ring_capture_reg[0];
                PATH_IDENT: serial_bit = device_identification_reg[0];
                default:    serial_bit = scan_bypass_bit_reg;
            endcase
        end
    end

    // Serial output, on the falling edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tdo_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg <= serial_bit; // RL3
        end
    end

    // Serial output enable, floating outside shift states
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tdo_oe_n_reg <= 1'b1; // RL10
        end else if (tck_fall) begin
            tdo_oe_n_reg <= ~shifting; // RL5
        end
    end

    assign tdo_out               = tdo_reg;
    assign tdo_oe_n_out          = tdo_oe_n_reg;
    assign mem_outputs_float_out = (scan_instruction_reg == INSTR_SAMPLE_Z); // RL21
    assign scan_instruction_out  = scan_instruction_reg;
    assign tap_reset_out         = (state_reg == ST_RESET); // RL9
endmodule : sram_boundary_scan_tap

// ### bench/scan_tap_asserts.sv
// Checker for the scan port
`timescale 1ns/1ps
module scan_tap_asserts
    import scan_tap_pkg::*;
(
    input wire logic                 clk_in,
    input wire logic                 rstn_in,
    input wire logic                 clk_en_in,
    input wire logic                 tck_in,
    input wire logic                 tms_in,
    input wire logic                 tms_driven_in,
    input wire logic                 tdi_in,
    input wire scan_tap_pkg::ring_t  pin_ring_in,
    input wire logic                 tdo_out,
    input wire logic                 tdo_oe_n_out,
    input wire logic                 mem_outputs_float_out,
    input wire scan_tap_pkg::instr_t scan_instruction_out,
    input wire logic                 tap_reset_out
);
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [2:0] hi_cnt;
    // Counts test clock rises with mode select high
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tck_s <= 3'h0;
            tms_s <= 2'h3;
            hi_cnt <= 3'h0;
        end else if (clk_en_in) begin
            tck_s <= {tck_s[1:0], tck_in};
            tms_s <= {tms_s[0], tms_in | ~tms_driven_in};
            if (tck_s[1] && !tck_s[2])
                hi_cnt <= tms_s[1] ? hi_cnt + {2'h0, hi_cnt < 3'h5} : 3'h0;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    chk_float_z_only: assert property (mem_outputs_float_out == (scan_instruction_out == INSTR_SAMPLE_Z))
        else $error("float mismatch");
    chk_reset_ident: assert property (tap_reset_out |-> scan_instruction_out == INSTR_IDENT)
        else $error("reset instr");
    chk_oe_off_reset: assert property (tap_reset_out |-> tdo_oe_n_out)
        else $error("oe in reset");
    chk_out_on_fall: assert property (($changed(tdo_out) || $changed(tdo_oe_n_out))
        |-> !tck_in && ($past(tck_in, 3) || $past(tck_in, 4) || $past(tck_in, 5))) else $error("out not on fall");
    chk_five_high_reset: assert property (hi_cnt == 3'h5 |-> ##[0:2] tap_reset_out)
        else $error("five high no reset");
    chk_instr_on_rise: assert property ($changed(scan_instruction_out) |-> tck_in)
        else $error("instr not on rise");
    chk_instr_no_shift: assert property ($changed(scan_instruction_out) |-> tdo_oe_n_out)
        else $error("instr in shift");
    chk_freeze_holds: assert property (!clk_en_in |=> $stable(scan_instruction_out) && $stable(tap_reset_out))
        else $error("freeze moved");
    cover property ($fell(tdo_oe_n_out));
    cover property ($fell(tap_reset_out));
    cover property ($rose(mem_outputs_float_out));
    cover property (hi_cnt == 3'h5);
endmodule : scan_tap_asserts
bind sram_boundary_scan_tap scan_tap_asserts chk_u (.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .tck_in(tck_in), .tms_in(tms_in), .tms_driven_in(tms_driven_in), .tdi_in(tdi_in), .pin_ring_in(pin_ring_in),
    .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .mem_outputs_float_out(mem_outputs_float_out),
    .scan_instruction_out(scan_instruction_out), .tap_reset_out(tap_reset_out));

// ### bench/scan_ctrl_model.sv
// External scan controller model
`timescale 1ns/1ps
module scan_ctrl_model (
    input  wire logic clk_in,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_n_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    output logic      tms_driven_out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        tms_driven_out = 1'b1;
    end
    // One test clock period, low then high, back low at the end
    task automatic step(input logic m, input logic d, output logic q);
        tms_out <= m;
        tdi_out <= d;
        repeat (4) @(posedge clk_in);
        tck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        q = tdo_oe_n_in ? 1'bz : tdo_in;
        tck_out <= 1'b0;
    endtask : step
    task automatic go(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'b1, q);
    endtask : go
    task automatic shift(input int n, input logic [68:0] din, output logic [68:0] dout);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        go(8'h1, 2);
    endtask : shift
    task automatic load(input logic [2:0] code, output logic [2:0] cap);
        logic [68:0] o;
        go(8'h3, 4);
        shift(3, {66'h0, code}, o);
        cap = o[2:0];
    endtask : load
endmodule : scan_ctrl_model

// ### bench/sram_boundary_scan_tap_tb.sv
// Self-checking bench for the scan port
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb;
    import scan_tap_pkg::*;
    logic clk_in, rstn_in, clk_en_in, tck, tms, tms_drv, tdi, tdo, oe_n, flt, trst;
    ring_t ring, got;
    instr_t ir;
    int failures, n_checks, cyc;
    sram_boundary_scan_tap dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .tck_in(tck),
        .tms_in(tms), .tms_driven_in(tms_drv), .tdi_in(tdi), .pin_ring_in(ring), .tdo_out(tdo),
        .tdo_oe_n_out(oe_n), .mem_outputs_float_out(flt), .scan_instruction_out(ir), .tap_reset_out(trst));
    scan_ctrl_model p_u (.clk_in(clk_in), .tdo_in(tdo), .tdo_oe_n_in(oe_n), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .tms_driven_out(tms_drv));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input ring_t e, input ring_t g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            failures++;
            end_sim;
        end
    end
    task automatic t_ident;
        chk("instr", INSTR_IDENT, ir);
        chk("oe_n", 1'b1, oe_n);
        p_u.go(8'h2, 4);
        p_u.shift(32, '1, got);
        chk("ident", IDENT_VALUE, got[31:0]);
        $display("ident test done");
    endtask : t_ident
    task automatic t_bypass;
        p_u.load(INSTR_BYPASS, got[2:0]);
        chk("ir cap", 3'h1, got[2:0]);
        chk("instr", INSTR_BYPASS, ir);
        p_u.go(8'h1, 3);
        p_u.shift(4, 69'hD, got);
        chk("bypass", 4'hA, got[3:0]);
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_ring;
        instr_t codes[3] = '{INSTR_EXT_TEST, INSTR_SAMPLE, INSTR_SAMPLE_Z};
        foreach (codes[k]) begin
            p_u.load(codes[k], got[2:0]);
            chk("float", codes[k] == INSTR_SAMPLE_Z, flt);
            ring <= ~ring;
            p_u.go(8'h1, 3);
            p_u.shift(69, '0, got);
            chk("ring", ring, got);
            chk("instr kept", codes[k], ir);
        end
        $display("ring test done");
    endtask : t_ring
    task automatic t_reset;
        p_u.go(8'h3, 4);
        p_u.go(8'h1F, 5);
        chk("tap reset", 1'b1, trst);
        chk("instr", INSTR_IDENT, ir);
        p_u.go(8'h0, 1);
        p_u.tms_driven_out <= 1'b0;
        p_u.go(8'h0, 5);
        chk("undriven", 1'b1, trst);
        p_u.tms_driven_out <= 1'b1;
        clk_en_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        clk_en_in <= 1'b1;
        p_u.go(8'h0, 1);
        p_u.load(INSTR_SAMPLE_Z, got[2:0]);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("rst float", 1'b0, flt);
        chk("rst instr", INSTR_IDENT, ir);
        chk("rst oe_n", 1'b1, oe_n);
        rstn_in <= 1'b1;
        $display("reset test done");
    endtask : t_reset
    initial begin
        clk_en_in = 1'b1;
        rstn_in = 1'b0;
        ring = {5'h1B, 64'h0123_4567_89AB_CDEF};
        failures = 0;
        n_checks = 0;
        cyc = 0;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        t_ident;
        t_bypass;
        t_ring;
        t_reset;
        end_sim;
    end
endmodule : sram_boundary_scan_tap_tb
